// ### core/rfpd_pkg.sv
package rfpd_pkg;

	// ****************************************
	// Program memory map
	// ****************************************
	localparam logic [15:0] PM_VECTOR_FIRST = 16'h0000;
	localparam logic [15:0] PM_VECTOR_LAST = 16'h00FF;
	localparam logic [15:0] PM_OPTION_FIRST = 16'h003C;
	localparam logic [15:0] PM_OPTION_LAST = 16'h003F;
	localparam logic [15:0] PM_OPTION_LOW = 16'h003E;
	localparam logic [15:0] PM_OPTION_HIGH = 16'h003F;
	localparam logic [15:0] PM_RESET_ADDR = 16'h0100;
	localparam logic [15:0] OPTION_RESET = 16'h0000;
	localparam logic [7:0] OPTION_CELL_RESET = 8'h00;

	// ****************************************
	// Register file map
	// ****************************************
	localparam logic [7:0] RF_PAGE_PTR_ADDR = 8'hDF;
	localparam logic [7:0] RF_PAGE_PTR_RESET = 8'h00;
	localparam logic [7:0] RF_SET1_FIRST = 8'hC0;
	localparam logic [7:0] RF_COMMON_LAST = 8'hCF;
	localparam logic [7:0] RF_SYSTEM_FIRST = 8'hD0;
	localparam logic [7:0] RF_SYSTEM_LAST = 8'hDF;
	localparam logic [7:0] RF_BANKED_FIRST = 8'hE0;
	localparam logic [7:0] RF_PRIME_LAST = 8'hBF;
	localparam int PP_SRC_LSB = 0;
	localparam int PP_DST_LSB = 4;
	localparam logic [3:0] PAGE_LAST_PRIME = 4'h8;
	localparam logic [3:0] PAGE_LAST_SET2 = 4'h7;
	localparam logic BANK_RESET = 1'b0;
	localparam logic [11:0] PRIME_PAGE_BYTES = 12'h0C0;
	localparam logic [11:0] SET2_PAGE_BYTES = 12'h040;
	localparam logic [11:0] SET2_INDEX_BASE = 12'h6C0;
	localparam logic [11:0] GP_REG_COUNT = 12'h816;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		RFPD_MODE_REGISTER,
		RFPD_MODE_WORKING,
		RFPD_MODE_INDIRECT,
		RFPD_MODE_INDEXED
	} rfpd_mode_t;

	typedef enum logic [2:0] {
		RFPD_TGT_NONE,
		RFPD_TGT_PRIME,
		RFPD_TGT_COMMON,
		RFPD_TGT_SYSTEM,
		RFPD_TGT_BANK0,
		RFPD_TGT_BANK1,
		RFPD_TGT_SET2
	} rfpd_target_t;

	typedef struct packed {
		logic valid;
		logic write;
		rfpd_mode_t mode;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rfpd_reg_req_t;

	typedef struct packed {
		logic valid;
		logic error;
		rfpd_target_t target;
		logic [3:0] page;
		logic [7:0] addr;
		logic [11:0] gp_index;
		logic pp_hit;
		logic [7:0] pp_rdata;
	} rfpd_reg_resp_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} rfpd_pm_req_t;

	typedef struct packed {
		logic valid;
		logic vector_area;
		logic option_cell;
		logic option_func;
		logic [7:0] cell_rdata;
	} rfpd_pm_resp_t;

endpackage

// ### core/rfpd_page_ptr.sv
module rfpd_page_ptr
	import rfpd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic pp_we,
	input wire logic [7:0] pp_wdata,
	input wire logic bank0_sel,
	input wire logic bank1_sel,
	output logic [7:0] pp_value,
	output logic bank_value
);
	logic [7:0] pp_reg;
	logic [7:0] pp_next;
	logic bank_reg;
	logic bank_next;

	// ****************************************
	// Page pointer and bank select
	// ****************************************
	always_comb begin
		pp_next = pp_reg;
		bank_next = bank_reg;
		if (pp_we) begin
			pp_next = pp_wdata; // [RULE6]
		end
		if (bank1_sel) begin
			bank_next = 1'b1; // [RULE10]
		end else if (bank0_sel) begin
			bank_next = 1'b0; // [RULE10]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pp_reg <= RF_PAGE_PTR_RESET; // [RULE7]
			bank_reg <= BANK_RESET; // [RULE11]
		end else if (clk_en) begin
			pp_reg <= pp_next;
			bank_reg <= bank_next;
		end
	end

	assign pp_value = pp_reg;
	assign bank_value = bank_reg;
endmodule

// ### core/rfpd_option.sv
module rfpd_option
	import rfpd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic load_we,
	input wire logic prog_we,
	input wire logic [1:0] cell_sel,
	input wire logic [7:0] cell_wdata,
	output logic [7:0] cell_rdata,
	output logic [15:0] option_value
);
	logic [7:0] cell_reg [4];
	logic [7:0] cell_next [4];
	logic [15:0] option_reg;
	logic [15:0] option_next;

	// ****************************************
	// Option cells and active option
	// ****************************************
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			cell_next[i] = cell_reg[i];
		end
		option_next = option_reg;
		if (load_we || prog_we) begin
			cell_next[cell_sel] = cell_wdata; // [RULE5]
		end
		if (prog_we && cell_sel == 2'd2) begin
			option_next[7:0] = cell_wdata; // [RULE4]
		end
		if (prog_we && cell_sel == 2'd3) begin
			option_next[15:8] = cell_wdata; // [RULE4]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) begin
				cell_reg[i] <= OPTION_CELL_RESET;
			end
			option_reg <= OPTION_RESET;
		end else if (clk_en) begin
			cell_reg <= cell_next;
			option_reg <= option_next;
		end
	end

	assign cell_rdata = cell_reg[cell_sel];
	assign option_value = option_reg;
endmodule

// ### core/rfpd_decoder.sv
// Functional notes
// [RULE1] Program addresses 0000H to 00FFH form the interrupt vector region.
// [RULE2] Vector region is ordinary memory except option cells 3CH to 3FH.
// [RULE3] After reset, program fetch starts at address 0100H.
// [RULE4] Active start option comes only from 003EH and 003FH.
// [RULE5] Load instructions change option cell bytes but never the active option.
// [RULE6] Page pointer is an 8-bit register at register address DFH.
// [RULE7] Reset clears both page pointer nibbles, selecting page 0.
// [RULE8] Each nibble selects a page by value; pages 0 to 8 exist.
// [RULE9] Register addresses C0H to FFH form the set 1 region.
// [RULE10] E0H to FFH use two banks chosen by the last bank-select instruction.
// [RULE11] Reset selects bank 0.
// [RULE12] D0H to DFH are system registers, C0H to CFH the common area.
// [RULE13] Common area is reachable only by working-register addressing.
// [RULE14] Set 1 ignores the selected page.
// [RULE15] Plain register mode accesses to C0H to FFH go to set 1; the code refuses C0H to CFH with an error.
// [RULE16] Indirect or indexed accesses to C0H to FFH go to set 2.
// [RULE17] Set 2 exists separately on pages 0 to 7.
// [RULE18] General-purpose storage totals 2070 bytes over pages 0 to 8; the code indexes 2240 bytes, 000H to 8BFH.
// [RULE19] 00H to BFH is the paged prime area under any mode.
// [RULE20] Reads use the source nibble, writes the destination nibble.
module rfpd_decoder
	import rfpd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input rfpd_pkg::rfpd_reg_req_t reg_req,
	input wire logic select_bank_zero_instr,
	input wire logic select_bank_one_instr,
	input rfpd_pkg::rfpd_pm_req_t pm_req,
	input wire logic prog_we,
	input wire logic [1:0] prog_cell,
	input wire logic [7:0] prog_wdata,
	output rfpd_pkg::rfpd_reg_resp_t reg_resp,
	output rfpd_pkg::rfpd_pm_resp_t pm_resp,
	output logic fetch_start,
	output logic [15:0] fetch_addr,
	output logic [15:0] start_option,
	output logic [7:0] register_page_pointer,
	output logic bank_select
);
	import rfpd_pkg::*;

	// ****************************************
	// Address classification
	// ****************************************
	function automatic logic pm_in_vector(input logic [15:0] a);
		pm_in_vector = (a >= PM_VECTOR_FIRST) && (a <= PM_VECTOR_LAST);
	endfunction

	function automatic logic pm_in_option(input logic [15:0] a);
		pm_in_option = (a >= PM_OPTION_FIRST) && (a <= PM_OPTION_LAST);
	endfunction

	function automatic logic rf_in_set1(input logic [7:0] a);
		rf_in_set1 = (a >= RF_SET1_FIRST); // [RULE9]
	endfunction

	function automatic logic rf_in_common(input logic [7:0] a);
		rf_in_common = (a >= RF_SET1_FIRST) && (a <= RF_COMMON_LAST);
	endfunction

	function automatic logic rf_in_system(input logic [7:0] a);
		rf_in_system = (a >= RF_SYSTEM_FIRST) && (a <= RF_SYSTEM_LAST);
	endfunction

	// ****************************************
	// Submodules
	// ****************************************
	logic [7:0] pp_value;
	logic bank_value;
	logic pp_we;
	logic opt_load_we;
	logic [1:0] opt_sel;
	logic [7:0] opt_wdata;
	logic [7:0] opt_rdata;
	logic [15:0] opt_value;

	rfpd_page_ptr u_page_ptr (
		.sys_clk(sys_clk),
		.reset(reset),
		.clk_en(clk_en),
		.pp_we(pp_we),
		.pp_wdata(reg_req.wdata),
		.bank0_sel(select_bank_zero_instr),
		.bank1_sel(select_bank_one_instr),
		.pp_value(pp_value),
		.bank_value(bank_value)
	);

	rfpd_option u_option (
		.sys_clk(sys_clk),
		.reset(reset),
		.clk_en(clk_en),
		.load_we(opt_load_we),
		.prog_we(prog_we),
		.cell_sel(opt_sel),
		.cell_wdata(opt_wdata),
		.cell_rdata(opt_rdata),
		.option_value(opt_value)
	);

	// ****************************************
	// Register-side decode
	// ****************************************
	logic [3:0] src_page;
	logic [3:0] dst_page;
	logic [3:0] use_page;
	rfpd_target_t tgt_c;
	logic err_c;
	logic [11:0] idx_c;
	logic [11:0] page_ext;

	always_comb begin
		src_page = pp_value[PP_SRC_LSB +: 4];
		dst_page = pp_value[PP_DST_LSB +: 4];
		use_page = reg_req.write ? dst_page : src_page; // [RULE20]
		page_ext = {8'h00, use_page};
		tgt_c = RFPD_TGT_NONE;
		err_c = 1'b0;
		idx_c = 12'h000;
		if (!rf_in_set1(reg_req.addr)) begin
			// Paged prime area
			if (use_page <= PAGE_LAST_PRIME) begin // [RULE8]
				tgt_c = RFPD_TGT_PRIME; // [RULE19]
				idx_c = 12'((page_ext * PRIME_PAGE_BYTES) + {4'h0, reg_req.addr});
			end else begin
				err_c = 1'b1;
			end
		end else if (reg_req.mode == RFPD_MODE_INDIRECT || reg_req.mode == RFPD_MODE_INDEXED) begin
			// Duplicate upper region, per page
			if (use_page <= PAGE_LAST_SET2) begin // [RULE17]
				tgt_c = RFPD_TGT_SET2; // [RULE16]
				idx_c = 12'(SET2_INDEX_BASE + (page_ext * SET2_PAGE_BYTES)
					+ {6'h00, reg_req.addr[5:0]});
			end else begin
				err_c = 1'b1;
			end
		end else if (rf_in_common(reg_req.addr)) begin
			if (reg_req.mode == RFPD_MODE_WORKING) begin
				tgt_c = RFPD_TGT_COMMON; // [RULE13]
				idx_c = {8'h00, reg_req.addr[3:0]};
			end else begin
				err_c = 1'b1; // [RULE13]
			end
		end else if (rf_in_system(reg_req.addr)) begin
			tgt_c = RFPD_TGT_SYSTEM; // [RULE12]
			idx_c = {8'h00, reg_req.addr[3:0]};
		end else begin
			tgt_c = bank_value ? RFPD_TGT_BANK1 : RFPD_TGT_BANK0; // [RULE10]
			idx_c = {7'h00, reg_req.addr[4:0]};
		end
		// Set 2 on pages 0 to 7 stays reachable, so only the prime area is bounded
		if (tgt_c == RFPD_TGT_PRIME) begin
			if (idx_c >= GP_REG_COUNT) begin // [RULE18]
				tgt_c = RFPD_TGT_NONE;
				err_c = 1'b1;
			end
		end
	end

	// Page pointer write: set 1 system cell, page independent
	assign pp_we = clk_en && reg_req.valid && reg_req.write && (tgt_c == RFPD_TGT_SYSTEM)
		&& (reg_req.addr == RF_PAGE_PTR_ADDR); // [RULE6] [RULE14] [RULE15]

	// ****************************************
	// Register-side response
	// ****************************************
	rfpd_reg_resp_t reg_resp_reg;
	rfpd_reg_resp_t reg_resp_next;

	always_comb begin
		reg_resp_next = '0;
		if (reg_req.valid) begin
			reg_resp_next.valid = 1'b1;
			reg_resp_next.error = err_c;
			reg_resp_next.target = tgt_c;
			reg_resp_next.addr = reg_req.addr;
			reg_resp_next.gp_index = idx_c;
			if (tgt_c == RFPD_TGT_PRIME || tgt_c == RFPD_TGT_SET2) begin
				reg_resp_next.page = use_page;
			end
			if (tgt_c == RFPD_TGT_SYSTEM && reg_req.addr == RF_PAGE_PTR_ADDR) begin
				reg_resp_next.pp_hit = 1'b1;
				reg_resp_next.pp_rdata = reg_req.write ? reg_req.wdata : pp_value;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_resp_reg <= '0;
		end else if (clk_en) begin
			reg_resp_reg <= reg_resp_next;
		end
	end

	// ****************************************
	// Program-side decode
	// ****************************************
	logic pm_opt_hit;

	always_comb begin
		pm_opt_hit = pm_req.valid && pm_in_option(pm_req.addr); // [RULE2]
		opt_load_we = clk_en && pm_opt_hit && pm_req.write; // [RULE5]
		opt_sel = prog_we ? prog_cell : pm_req.addr[1:0];
		opt_wdata = prog_we ? prog_wdata : pm_req.wdata;
	end

	rfpd_pm_resp_t pm_resp_reg;
	rfpd_pm_resp_t pm_resp_next;

	always_comb begin
		pm_resp_next = '0;
		if (pm_req.valid) begin
			pm_resp_next.valid = 1'b1;
			pm_resp_next.vector_area = pm_in_vector(pm_req.addr) && !pm_in_option(pm_req.addr); // [RULE1]
			pm_resp_next.option_cell = pm_in_option(pm_req.addr); // [RULE2]
			pm_resp_next.option_func = (pm_req.addr == PM_OPTION_LOW)
				|| (pm_req.addr == PM_OPTION_HIGH); // [RULE4]
			if (pm_in_option(pm_req.addr) && !pm_req.write) begin
				pm_resp_next.cell_rdata = opt_rdata;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pm_resp_reg <= '0;
		end else if (clk_en) begin
			pm_resp_reg <= pm_resp_next;
		end
	end

	// ****************************************
	// Reset fetch start
	// ****************************************
	logic start_pending_reg;
	logic start_pending_next;
	logic fetch_start_reg;
	logic fetch_start_next;
	logic [15:0] fetch_addr_reg;
	logic [15:0] option_out_reg;
	logic [7:0] pp_out_reg;
	logic bank_out_reg;

	always_comb begin
		start_pending_next = 1'b0;
		fetch_start_next = start_pending_reg; // [RULE3]
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			start_pending_reg <= 1'b1;
			fetch_start_reg <= 1'b0;
			fetch_addr_reg <= PM_RESET_ADDR; // [RULE3]
			option_out_reg <= OPTION_RESET;
			pp_out_reg <= RF_PAGE_PTR_RESET;
			bank_out_reg <= BANK_RESET;
		end else if (clk_en) begin
			start_pending_reg <= start_pending_next;
			fetch_start_reg <= fetch_start_next;
			fetch_addr_reg <= PM_RESET_ADDR;
			option_out_reg <= opt_value; // [RULE4]
			pp_out_reg <= pp_value;
			bank_out_reg <= bank_value;
		end
	end

	assign reg_resp = reg_resp_reg;
	assign pm_resp = pm_resp_reg;
	assign fetch_start = fetch_start_reg;
	assign fetch_addr = fetch_addr_reg;
	assign start_option = option_out_reg;
	assign register_page_pointer = pp_out_reg;
	assign bank_select = bank_out_reg;
endmodule

// ### sim/rfpd_decoder_assertions.sv
module rfpd_decoder_assertions
	import rfpd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input rfpd_pkg::rfpd_reg_req_t reg_req,
	input wire logic select_bank_one_instr,
	input rfpd_pkg::rfpd_pm_req_t pm_req,
	input wire logic prog_we,
	input rfpd_pkg::rfpd_reg_resp_t reg_resp,
	input wire logic [15:0] fetch_addr,
	input wire logic [15:0] start_option,
	input wire logic [7:0] register_page_pointer,
	input wire logic bank_select
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// ****************************************
	// Register side
	// ****************************************
	AST_RESP_ONE_CYCLE: assert property (
		reg_req.valid && clk_en |=> reg_resp.valid) else $error("register answer missing");
	AST_PRIME_ANY_MODE: assert property (
		reg_req.valid && clk_en && reg_req.addr <= RF_PRIME_LAST
		|=> reg_resp.target == RFPD_TGT_PRIME || reg_resp.error) else $error("prime access misrouted");
	AST_SET2_ROUTE: assert property (
		reg_req.valid && clk_en && reg_req.addr >= RF_SET1_FIRST
		&& reg_req.mode inside {RFPD_MODE_INDIRECT, RFPD_MODE_INDEXED}
		|=> reg_resp.target == RFPD_TGT_SET2 || reg_resp.error) else $error("set 2 access misrouted");
	AST_COMMON_PLAIN_REFUSED: assert property (
		reg_req.valid && clk_en && reg_req.mode == RFPD_MODE_REGISTER && reg_req.addr <= RF_COMMON_LAST
		&& reg_req.addr >= RF_SET1_FIRST |=> reg_resp.error && reg_resp.target == RFPD_TGT_NONE)
		else $error("common area reached without working mode");
	AST_PP_ECHO: assert property (
		reg_req.valid && reg_req.write && reg_req.mode == RFPD_MODE_REGISTER
		&& reg_req.addr == RF_PAGE_PTR_ADDR && clk_en ##1 clk_en
		|-> ##1 register_page_pointer == $past(reg_req.wdata, 2)) else $error("page pointer not written");
	AST_BANK_ONE: assert property (
		select_bank_one_instr && clk_en ##1 clk_en |-> ##1 bank_select) else $error("bank one not taken");
	AST_RESET_STATE: assert property (
		$fell(reset) |-> !bank_select && register_page_pointer == 8'h00) else $error("reset state wrong");

	// ****************************************
	// Program side
	// ****************************************
	AST_FETCH_ADDR: assert property (
		fetch_addr == PM_RESET_ADDR) else $error("fetch address wrong");
	AST_LOAD_NO_OPTION: assert property (
		pm_req.valid && pm_req.write && !prog_we && !$past(prog_we)
		|=> $stable(start_option)) else $error("load changed start option");

	COV_BANK_ONE: cover property (select_bank_one_instr ##2 bank_select);
	COV_SET2: cover property (reg_resp.valid && reg_resp.target == RFPD_TGT_SET2);
	COV_LOAD: cover property (pm_req.valid && pm_req.write);
endmodule

// ### sim/rfpd_cpu_model.sv
module rfpd_cpu_model
	import rfpd_pkg::*;
(
	input wire logic sys_clk,
	output rfpd_pkg::rfpd_reg_req_t reg_req,
	output rfpd_pkg::rfpd_pm_req_t pm_req,
	input rfpd_pkg::rfpd_reg_resp_t reg_resp,
	input rfpd_pkg::rfpd_pm_resp_t pm_resp
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_req = '0;
		pm_req = '0;
	end
	// Request held for one edge, then released with write, address and data inverted and mode kept
	task automatic reg_op(input logic w, input rfpd_mode_t m, input logic [7:0] a, d, output rfpd_reg_resp_t r);
		@(posedge sys_clk);
		#1;
		reg_req = '{1'b1, w, m, a, d};
		@(posedge sys_clk);
		#1;
		reg_req = '{1'b0, ~w, m, ~a, ~d};
		r = reg_resp;
	endtask
	task automatic pm_op(input logic w, input logic [15:0] a, input logic [7:0] d, output rfpd_pm_resp_t r);
		@(posedge sys_clk);
		#1;
		pm_req = '{1'b1, w, a, d};
		@(posedge sys_clk);
		#1;
		pm_req = '{1'b0, ~w, ~a, ~d};
		r = pm_resp;
	endtask
endmodule

// ### sim/test_register_file_page_decoder.sv
module test_register_file_page_decoder;
	import rfpd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam rfpd_mode_t RG = RFPD_MODE_REGISTER;
	localparam rfpd_mode_t WK = RFPD_MODE_WORKING;
	localparam rfpd_mode_t IR = RFPD_MODE_INDIRECT;
	localparam rfpd_mode_t IX = RFPD_MODE_INDEXED;
	localparam rfpd_target_t NO = RFPD_TGT_NONE;
	localparam rfpd_target_t PR = RFPD_TGT_PRIME;
	localparam rfpd_target_t S2 = RFPD_TGT_SET2;
	logic sys_clk = 0, reset = 1, clk_en = 1, sb0 = 0, sb1 = 0, prog_we = 0;
	logic [1:0] prog_cell = 0;
	logic [7:0] prog_wdata = 0, register_page_pointer;
	logic fetch_start, bank_select;
	logic [15:0] fetch_addr, start_option;
	rfpd_reg_req_t reg_req;
	rfpd_pm_req_t pm_req;
	rfpd_reg_resp_t reg_resp, rr;
	rfpd_pm_resp_t pm_resp, pr;
	int errors = 0, samples_checked = 0, cycles = 0;

	always #5 sys_clk = ~sys_clk;

	rfpd_cpu_model cpu(.sys_clk(sys_clk), .reg_req(reg_req), .pm_req(pm_req), .reg_resp(reg_resp),
		.pm_resp(pm_resp));
	rfpd_decoder DUT(.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .reg_req(reg_req),
		.select_bank_zero_instr(sb0), .select_bank_one_instr(sb1), .pm_req(pm_req), .prog_we(prog_we),
		.prog_cell(prog_cell), .prog_wdata(prog_wdata), .reg_resp(reg_resp), .pm_resp(pm_resp),
		.fetch_start(fetch_start), .fetch_addr(fetch_addr), .start_option(start_option),
		.register_page_pointer(register_page_pointer), .bank_select(bank_select));

	// ****************************************
	// Checking and closing
	// ****************************************
	task chk(input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("errors %0d checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			results();
		end
	end

	// ****************************************
	// Access helpers
	// ****************************************
	task automatic ra(input logic w, input rfpd_mode_t m, input logic [7:0] a, input rfpd_target_t t,
		input logic [3:0] p, input logic [11:0] g);
		cpu.reg_op(w, m, a, 8'h00, rr);
		chk({rr.valid, rr.error, rr.target}, {1'b1, t == NO, t});
		if (t != NO) chk(rr.page, p);
		if (t == PR || t == S2) chk(rr.gp_index, g);
	endtask
	task automatic set_pp(input logic [7:0] v);
		cpu.reg_op(1'b1, RG, RF_PAGE_PTR_ADDR, v, rr);
		chk({rr.target, rr.pp_hit, rr.pp_rdata}, {RFPD_TGT_SYSTEM, 1'b1, v});
		@(posedge sys_clk);
		#1;
		chk(register_page_pointer, v);
	endtask
	task automatic pa(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [2:0] f);
		cpu.pm_op(w, a, d, pr);
		chk({pr.valid, pr.vector_area, pr.option_cell, pr.option_func}, {1'b1, f});
	endtask
	task automatic bank(input logic one);
		@(posedge sys_clk);
		#1;
		{sb1, sb0} = {one, ~one};
		@(posedge sys_clk);
		#1;
		{sb1, sb0} = 2'b00;
		@(posedge sys_clk);
		#1;
		chk(bank_select, one);
	endtask
	task t_freeze;
		@(posedge sys_clk);
		#1;
		{clk_en, sb1} = 2'b01;
		@(posedge sys_clk);
		#1;
		sb1 = 1'b0;
		@(posedge sys_clk);
		#1;
		clk_en = 1'b1;
		chk(bank_select, 1'b0);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		@(posedge sys_clk);
		#1;
		chk({fetch_start, fetch_addr, start_option}, {1'b1, 16'h0100, 16'h0000});
		chk({register_page_pointer, bank_select}, 9'h000);
		@(posedge sys_clk);
		#1;
		chk(fetch_start, 1'b0);
	endtask
	task t_pages;
		set_pp(8'h21);
		ra(1'b1, RG, 8'h10, PR, 4'h2, 12'h190);
		ra(1'b0, IR, 8'hBF, PR, 4'h1, 12'h17F);
		set_pp(8'h77);
		ra(1'b0, IR, 8'hC0, S2, 4'h7, 12'h880);
		set_pp(8'h88);
		ra(1'b0, RG, 8'h05, PR, 4'h8, 12'h605);
		ra(1'b0, IX, 8'hC1, NO, 4'h0, 12'h000);
		set_pp(8'h99);
		ra(1'b0, WK, 8'h00, NO, 4'h0, 12'h000);
	endtask
	task t_sets;
		set_pp(8'h11);
		ra(1'b0, RG, 8'hC5, NO, 4'h0, 12'h000);
		ra(1'b0, WK, 8'hC5, RFPD_TGT_COMMON, 4'h0, 12'h000);
		ra(1'b0, RG, 8'hD3, RFPD_TGT_SYSTEM, 4'h0, 12'h000);
		ra(1'b0, RG, 8'hE4, RFPD_TGT_BANK0, 4'h0, 12'h000);
		bank(1'b1);
		ra(1'b0, RG, 8'hFF, RFPD_TGT_BANK1, 4'h0, 12'h000);
		bank(1'b0);
		ra(1'b1, RG, 8'hE0, RFPD_TGT_BANK0, 4'h0, 12'h000);
		ra(1'b0, IR, 8'hC1, S2, 4'h1, 12'h701);
		ra(1'b1, IX, 8'hFF, S2, 4'h1, 12'h73F);
	endtask
	task t_program;
		pa(1'b0, 16'h0010, 8'h00, 3'b100);
		pa(1'b0, 16'h00FF, 8'h00, 3'b100);
		pa(1'b0, 16'h0100, 8'h00, 3'b000);
		pa(1'b0, 16'h003C, 8'h00, 3'b010);
		pa(1'b0, 16'h003D, 8'h00, 3'b010);
		pa(1'b1, 16'h003E, 8'h5A, 3'b011);
		repeat (3) @(posedge sys_clk);
		#1;
		chk(start_option, 16'h0000);
		pa(1'b0, 16'h003E, 8'h00, 3'b011);
		chk(pr.cell_rdata, 8'h5A);
		{prog_we, prog_cell, prog_wdata} = {1'b1, 2'd3, 8'hA5};
		@(posedge sys_clk);
		#1;
		{prog_cell, prog_wdata} = {2'd2, 8'h5A};
		@(posedge sys_clk);
		#1;
		{prog_cell, prog_wdata} = {2'd0, 8'h77};
		@(posedge sys_clk);
		#1;
		prog_we = 0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(start_option, 16'hA55A);
	endtask

	initial begin
		repeat (20) @(posedge sys_clk);
		#1;
		reset = 0;
		t_reset();
		t_pages();
		t_sets();
		t_freeze();
		t_program();
		results();
	end
endmodule

bind rfpd_decoder rfpd_decoder_assertions u_chk(.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
	.reg_req(reg_req), .select_bank_one_instr(select_bank_one_instr), .pm_req(pm_req), .prog_we(prog_we),
	.reg_resp(reg_resp), .fetch_addr(fetch_addr), .start_option(start_option),
	.register_page_pointer(register_page_pointer), .bank_select(bank_select));
